// file: kms_pkg.sv
// Summary of operation
// - timing derives from one master oscillator clock
// - 14-bit shift ring decodes phases, read strobe
// - 4-bit counter on phase two decodes clocks
// - scan_hold low lets step clock advance counter
// - counter visits all 128 matrix positions
// - end of 128-position cycle sets key_found_n high
// - closure found: key_found_n low next step
// - host takes position as key code minus one
// - code valid 76.8 us unless hold raised
// - interrupt when key_found_n goes low
// - modifier keys raise no key interrupt
// - modifier status on lines apart from code
// - upper case modifier triggers display view state
// - terminal keys report ascii style codes
// - pad, editing and function keys codes
package kms_pkg;

  // ----------------------------------------------------------------
  // system timing
  // ----------------------------------------------------------------
  localparam int MASTER_OSC_HZ = 12500000;
  localparam int MASTER_CYCLE_NS = 80;
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int RING_W = 14;
  localparam logic [13:0] RING_RST = 14'h0001;
  localparam int PH1_FIRST = 0;
  localparam int PH1_LAST = 5;
  localparam int PH2_FIRST = 7;
  localparam int PH2_LAST = 12;
  localparam int RDE_FIRST = 9;
  localparam int RDE_LAST = 12;
  localparam int REF_W = 4;
  localparam logic [3:0] REF_RST = 4'h0;
  localparam logic [3:0] REF_LAST = 4'hf;
  localparam int GUARD_BIT = 3;
  localparam int TAPE_BIT = 2;

  // ----------------------------------------------------------------
  // keyboard scan
  // ----------------------------------------------------------------
  localparam int POS_W = 7;
  localparam int POSITIONS = 128;
  localparam logic [6:0] POS_RST = 7'h00;
  localparam logic [6:0] POS_LAST = 7'h7f;
  localparam logic [6:0] POS_ONE = 7'h01;
  localparam int KEY_VALID_NS = 76800;
  localparam int KEY_VALID_CYC = KEY_VALID_NS / SYS_CLK_PERIOD_NS;
  localparam int WIN_W = 10;
  localparam logic [9:0] WIN_LAST = 10'(KEY_VALID_CYC - 1);
  localparam logic [9:0] WIN_RST = 10'h000;

  // codes as wired: matrix position is code minus one
  localparam logic [6:0] CODE_A = 7'h41;
  localparam logic [6:0] CODE_Z = 7'h5a;
  localparam logic [6:0] CODE_DIGIT0 = 7'h30;
  localparam logic [6:0] CODE_DIGIT9 = 7'h39;
  localparam logic [6:0] CODE_BACKSPACE = 7'h08;
  localparam logic [6:0] CODE_LINE_FEED = 7'h0a;
  localparam logic [6:0] CODE_RETURN = 7'h0d;
  localparam logic [6:0] CODE_ESCAPE = 7'h1b;
  localparam logic [6:0] CODE_PAD0 = 7'h20;
  localparam logic [6:0] CODE_PAD9 = 7'h29;
  localparam logic [6:0] CODE_EDIT_FIRST = 7'h70;
  localparam logic [6:0] CODE_EDIT_LAST = 7'h74;
  localparam logic [6:0] CODE_FUNC1 = 7'h60;
  localparam logic [6:0] CODE_FUNC10 = 7'h69;

  typedef enum logic [1:0] {
    KMS_SCAN,
    KMS_FOUND,
    KMS_REPORT,
    KMS_FROZEN
  } kms_state_t;

  // ----------------------------------------------------------------
  // host controller registers (avalon byte addresses)
  // ----------------------------------------------------------------
  localparam int AV_AW = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_CLR = 5'h0c;
  localparam logic [4:0] REG_IRQ_EN = 5'h10;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_RELEASE_BIT = 1;
  localparam int ST_POS_LSB = 0;
  localparam int ST_VALID_BIT = 7;
  localparam int ST_UPPER_BIT = 8;
  localparam int ST_CONTROL_BIT = 9;
  localparam int ST_HOLD_BIT = 10;
  localparam int IRQ_W = 2;
  localparam int IRQ_KEY_BIT = 0;
  localparam int IRQ_VIEW_BIT = 1;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

// file: kms_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface kms_link_if;
  logic scan_hold;
  logic key_found_n;
  logic key_irq;
  logic [6:0] key_code_lines;
  logic upper_case_modifier_n;
  logic control_modifier_n;

  modport dev (
    input scan_hold,
    output key_found_n,
    output key_irq,
    output key_code_lines,
    output upper_case_modifier_n,
    output control_modifier_n
  );

  modport host (
    output scan_hold,
    input key_found_n,
    input key_irq,
    input key_code_lines,
    input upper_case_modifier_n,
    input control_modifier_n
  );
endinterface
`default_nettype wire

// file: kms_scanner.sv
`timescale 1ns/1ps
`default_nettype none
module kms_scanner (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // keyboard pins
  input wire logic [127:0] i_key_matrix,
  input wire logic i_upper_case_n,
  input wire logic i_control_n,
  // timing chain and view trigger outputs
  output logic o_clock_phase_one,
  output logic o_clock_phase_two,
  output logic o_read_strobe,
  output logic [3:0] o_refresh_clocks,
  output logic o_phosphor_guard_clock,
  output logic o_tape_source_clock,
  output logic o_refresh_scan_clock,
  output logic o_view_trigger,
  // link to host
  kms_link_if.dev lnk
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [13:0] ring;
    logic ph1;
    logic ph2;
    logic read_strobe;
    logic [3:0] ref_cnt;
    logic [3:0] refclk;
    logic guard;
    logic tape;
    logic rscan;
    logic [127:0] mat_s1;
    logic [127:0] mat_s2;
    logic [1:0] upper_s;
    logic [1:0] ctrl_s;
    logic upper_prev;
    logic view;
    kms_pkg::kms_state_t st;
    logic [6:0] pos;
    logic [6:0] code;
    logic found_n;
    logic irq;
    logic [9:0] win;
  } kms_dev_t;

  kms_dev_t cur_ff;
  kms_dev_t nxt_ff;
  logic step;
  logic closed;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ff = cur_ff;
    // the system clock stands in for the master oscillator
    // one-hot ring, phases decoded from its next value
    nxt_ff.ring = {cur_ff.ring[12:0], cur_ff.ring[13]};
    nxt_ff.ph1 = |nxt_ff.ring[kms_pkg::PH1_LAST:kms_pkg::PH1_FIRST];
    nxt_ff.ph2 = |nxt_ff.ring[kms_pkg::PH2_LAST:kms_pkg::PH2_FIRST];
    nxt_ff.read_strobe = |nxt_ff.ring[kms_pkg::RDE_LAST:kms_pkg::RDE_FIRST];
    // refresh counter advances on each phase two start
    if (nxt_ff.ring[kms_pkg::PH2_FIRST]) begin
      nxt_ff.ref_cnt = cur_ff.ref_cnt + 4'h1;
    end
    nxt_ff.refclk = 4'h0;
    nxt_ff.refclk[nxt_ff.ref_cnt[1:0]] = nxt_ff.ph2;
    nxt_ff.guard = nxt_ff.ref_cnt[kms_pkg::GUARD_BIT];
    nxt_ff.tape = nxt_ff.ref_cnt[kms_pkg::TAPE_BIT];
    // scan clock pulses once per counter wrap
    nxt_ff.rscan = nxt_ff.ring[kms_pkg::PH2_FIRST] &&
                   (cur_ff.ref_cnt == kms_pkg::REF_LAST);

    // pins pass two flops before use
    nxt_ff.mat_s1 = i_key_matrix;
    nxt_ff.mat_s2 = cur_ff.mat_s1;
    nxt_ff.upper_s = {cur_ff.upper_s[0], i_upper_case_n};
    nxt_ff.ctrl_s = {cur_ff.ctrl_s[0], i_control_n};
    nxt_ff.upper_prev = cur_ff.upper_s[1];
    // assertion edge of upper case wakes the display
    nxt_ff.view = cur_ff.upper_prev && !cur_ff.upper_s[1];

    nxt_ff.irq = 1'b0;
    case (cur_ff.st)
      kms_pkg::KMS_SCAN: begin
        // steps only count while scan_hold is low
        if (step && !lnk.scan_hold) begin
          if (closed) begin
            // counter stops, key_found_n held high for now
            nxt_ff.found_n = 1'b1;
            nxt_ff.st = kms_pkg::KMS_FOUND;
          end else begin
            // walk every matrix position in turn
            nxt_ff.pos = cur_ff.pos + kms_pkg::POS_ONE;
            nxt_ff.code = cur_ff.pos + 7'h2;
            // end of cycle sets key_found_n high
            if (cur_ff.pos == kms_pkg::POS_LAST) begin
              nxt_ff.found_n = 1'b1;
            end
          end
        end
      end
      kms_pkg::KMS_FOUND: begin
        // next step drops key_found_n, code readable
        if (step) begin
          nxt_ff.found_n = 1'b0;
          nxt_ff.irq = 1'b1;
          nxt_ff.win = kms_pkg::WIN_RST;
          nxt_ff.st = kms_pkg::KMS_REPORT;
        end
      end
      kms_pkg::KMS_REPORT: begin
        // hold inside the window keeps the code
        if (lnk.scan_hold) begin
          nxt_ff.st = kms_pkg::KMS_FROZEN;
        end else if (cur_ff.win == kms_pkg::WIN_LAST) begin
          nxt_ff.pos = cur_ff.pos + kms_pkg::POS_ONE;
          nxt_ff.code = cur_ff.pos + 7'h2;
          nxt_ff.st = kms_pkg::KMS_SCAN;
        end else begin
          nxt_ff.win = cur_ff.win + 10'h001;
        end
      end
      kms_pkg::KMS_FROZEN: begin
        if (!lnk.scan_hold) begin
          nxt_ff.pos = cur_ff.pos + kms_pkg::POS_ONE;
          nxt_ff.code = cur_ff.pos + 7'h2;
          nxt_ff.st = kms_pkg::KMS_SCAN;
        end
      end
      default: begin
        nxt_ff.st = kms_pkg::KMS_SCAN;
      end
    endcase
  end

  // modifiers sit outside the matrix, never stop a scan
  assign closed = cur_ff.mat_s2[cur_ff.pos];
  assign step = cur_ff.rscan;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cur_ff <= '0;
      cur_ff.ring <= kms_pkg::RING_RST;
      cur_ff.ref_cnt <= kms_pkg::REF_RST;
      cur_ff.upper_s <= 2'h3;
      cur_ff.ctrl_s <= 2'h3;
      cur_ff.upper_prev <= 1'b1;
      cur_ff.st <= kms_pkg::KMS_SCAN;
      cur_ff.pos <= kms_pkg::POS_RST;
      cur_ff.code <= kms_pkg::POS_ONE;
      cur_ff.found_n <= 1'b1;
      cur_ff.win <= kms_pkg::WIN_RST;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_clock_phase_one = cur_ff.ph1;
  assign o_clock_phase_two = cur_ff.ph2;
  assign o_read_strobe = cur_ff.read_strobe;
  assign o_refresh_clocks = cur_ff.refclk;
  assign o_phosphor_guard_clock = cur_ff.guard;
  assign o_tape_source_clock = cur_ff.tape;
  assign o_refresh_scan_clock = cur_ff.rscan;
  assign o_view_trigger = cur_ff.view;
  assign lnk.key_found_n = cur_ff.found_n;
  assign lnk.key_irq = cur_ff.irq;
  // code is position plus one, wiring sets key values
  // pad, editing, function codes by wiring
  assign lnk.key_code_lines = cur_ff.code;
  // modifier levels on their own lines
  assign lnk.upper_case_modifier_n = cur_ff.upper_s[1];
  assign lnk.control_modifier_n = cur_ff.ctrl_s[1];

endmodule
`default_nettype wire

// file: kms_host.sv
`timescale 1ns/1ps
`default_nettype none
module kms_host (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // interrupt
  output logic o_irq,
  // link to scanner
  kms_link_if.host lnk
);

  typedef struct packed {
    logic wait_n;
    logic wait_req;
    logic [31:0] rdata;
    logic run;
    logic held;
    logic hold;
    logic [6:0] pos;
    logic upper_n;
    logic ctrl_n;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic irq;
    logic upper_prev;
  } kms_host_t;

  kms_host_t cur_ff;
  kms_host_t nxt_ff;
  logic req;
  logic wr_go;
  logic [1:0] ev;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ff = cur_ff;
    ev = 2'b00;
    status = kms_pkg::READ_ZERO;
    status[kms_pkg::ST_POS_LSB +: 7] = cur_ff.pos;
    status[kms_pkg::ST_VALID_BIT] = cur_ff.held;
    status[kms_pkg::ST_UPPER_BIT] = cur_ff.upper_n;
    status[kms_pkg::ST_CONTROL_BIT] = cur_ff.ctrl_n;
    status[kms_pkg::ST_HOLD_BIT] = cur_ff.hold;

    // one wait cycle, then the answer
    nxt_ff.wait_n = req && !cur_ff.wait_n;
    nxt_ff.wait_req = !nxt_ff.wait_n;
    if (req && !cur_ff.wait_n) begin
      case (i_avs_address)
        kms_pkg::REG_CTRL: nxt_ff.rdata = {31'h0, cur_ff.run};
        kms_pkg::REG_STATUS: nxt_ff.rdata = status;
        kms_pkg::REG_IRQ_STAT: nxt_ff.rdata = {30'h0, cur_ff.irq_stat};
        kms_pkg::REG_IRQ_EN: nxt_ff.rdata = {30'h0, cur_ff.irq_en};
        default: nxt_ff.rdata = kms_pkg::READ_ZERO;
      endcase
    end

    if (lnk.key_irq) begin
      // raise hold at once, well inside the window
      nxt_ff.held = 1'b1;
      // matrix position is the code minus one
      nxt_ff.pos = lnk.key_code_lines - 7'h1;
      nxt_ff.upper_n = lnk.upper_case_modifier_n;
      nxt_ff.ctrl_n = lnk.control_modifier_n;
      ev[kms_pkg::IRQ_KEY_BIT] = 1'b1;
    end
    nxt_ff.upper_prev = lnk.upper_case_modifier_n;
    ev[kms_pkg::IRQ_VIEW_BIT] = cur_ff.upper_prev &&
                                !lnk.upper_case_modifier_n;

    if (wr_go) begin
      case (i_avs_address)
        kms_pkg::REG_CTRL: begin
          nxt_ff.run = i_avs_writedata[kms_pkg::CTRL_RUN_BIT];
          if (i_avs_writedata[kms_pkg::CTRL_RELEASE_BIT] &&
              !lnk.key_irq) begin
            nxt_ff.held = 1'b0;
          end
        end
        kms_pkg::REG_IRQ_CLR: begin
          nxt_ff.irq_stat = cur_ff.irq_stat & ~i_avs_writedata[1:0];
        end
        kms_pkg::REG_IRQ_EN: nxt_ff.irq_en = i_avs_writedata[1:0];
        default: begin
        end
      endcase
    end
    // set beats a clear in the same cycle
    nxt_ff.irq_stat = nxt_ff.irq_stat | ev;
    // scan_hold low only while running and not holding
    nxt_ff.hold = !nxt_ff.run || nxt_ff.held;
    nxt_ff.irq = |(nxt_ff.irq_stat & nxt_ff.irq_en);
  end

  assign req = i_avs_read || i_avs_write;
  assign wr_go = i_avs_write && cur_ff.wait_n;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cur_ff <= '0;
      cur_ff.hold <= 1'b1;
      cur_ff.wait_req <= 1'b1;
      cur_ff.upper_n <= 1'b1;
      cur_ff.ctrl_n <= 1'b1;
      cur_ff.upper_prev <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign o_avs_readdata = cur_ff.rdata;
  assign o_avs_waitrequest = cur_ff.wait_req;
  assign o_irq = cur_ff.irq;
  assign lnk.scan_hold = cur_ff.hold;

endmodule
`default_nettype wire

// file: kms_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module kms_link_asserts (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // link signals
  input wire logic scan_hold,
  input wire logic key_found_n,
  input wire logic key_irq,
  input wire logic [6:0] key_code_lines,
  input wire logic upper_case_modifier_n,
  input wire logic control_modifier_n
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // link checks
  // ----------------------------------------------------------------
  a_irq_on_fall:
    assert property ($fell(key_found_n) |-> key_irq)
    else $error("no interrupt when key line fell");
  a_irq_only_fall:
    assert property (key_irq |-> !key_found_n && $past(key_found_n))
    else $error("interrupt without key line falling");
  a_irq_single_pulse:
    assert property (key_irq |=> (!key_irq) [*8])
    else $error("interrupt pulse too long");
  a_hold_after_irq:
    assert property (key_irq |=> scan_hold)
    else $error("host did not hold scan after interrupt");
  a_code_stays_valid:
    assert property (key_irq |=> ($stable(key_code_lines)) [*8])
    else $error("key code moved inside valid window");
  a_frozen_code:
    assert property (scan_hold && $past(scan_hold) && !key_found_n
      |-> $stable(key_code_lines))
    else $error("key code moved while held");
  a_found_frozen:
    assert property (scan_hold && !key_found_n |=> !key_found_n)
    else $error("key line rose while held");
  a_rise_unheld:
    assert property ($rose(key_found_n) |-> $past(scan_hold) == 1'b0)
    else $error("key line rose while scan held");

  c_key: cover property (key_irq);
  c_lap_end: cover property ($rose(key_found_n));
  c_upper: cover property ($fell(upper_case_modifier_n));
  c_control: cover property ($fell(control_modifier_n));
endmodule
`default_nettype wire

// file: keyboard_matrix_scanner_bench.sv
`timescale 1ns/1ps
`default_nettype none
module keyboard_matrix_scanner_bench;
  logic clk;
  logic rst_n;
  logic [127:0] keys;
  logic upper_n;
  logic control_n;
  logic [4:0] av_addr;
  logic av_rd;
  logic av_wr;
  logic [31:0] av_wd;
  logic [31:0] av_rdata;
  logic av_wait;
  logic irq;
  logic ph1;
  logic ph2;
  logic view;
  logic read_strobe;
  logic rscan;
  logic [3:0] refclk;
  logic guard;
  logic tape;
  logic [31:0] rd;
  int n_errors;
  int samples_checked;
  int cyc;

  kms_link_if lnk ();
  kms_scanner u_kms_scanner (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_key_matrix(keys), .i_upper_case_n(upper_n), .i_control_n(control_n),
    .o_clock_phase_one(ph1), .o_clock_phase_two(ph2),
    .o_read_strobe(read_strobe), .o_refresh_clocks(refclk),
    .o_phosphor_guard_clock(guard), .o_tape_source_clock(tape),
    .o_refresh_scan_clock(rscan),
    .o_view_trigger(view), .lnk(lnk.dev));
  kms_host u_kms_host (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wd), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(av_wait), .o_irq(irq), .lnk(lnk.host));
  kms_link_asserts u_kms_link_asserts (.i_sys_clk(clk), .i_rst_n(rst_n),
    .scan_hold(lnk.scan_hold), .key_found_n(lnk.key_found_n),
    .key_irq(lnk.key_irq), .key_code_lines(lnk.key_code_lines),
    .upper_case_modifier_n(lnk.upper_case_modifier_n),
    .control_modifier_n(lnk.control_modifier_n));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_addr <= a;
    av_wr <= wr;
    av_rd <= !wr;
    av_wd <= d;
    @(posedge clk);
    while (av_wait !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check("bus answered", n < 50, 1);
    rd = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge clk);
  endtask

  // waits for the key pulse; long because a lap is 128 steps of 224
  task wait_key();
    int n;
    n = 0;
    while (lnk.key_irq !== 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset();
    check("key line idle", lnk.key_found_n, 1);
    check("scan held", lnk.scan_hold, 1);
    check("irq idle", irq, 0);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped read", rd, 32'h0);
  endtask

  task t_timing();
    int p1;
    int p2;
    int both;
    int rs;
    int stray;
    p1 = 0;
    p2 = 0;
    both = 0;
    rs = 0;
    stray = 0;
    repeat (14) begin
      @(posedge clk);
      p1 += int'(ph1 === 1'b1);
      p2 += int'(ph2 === 1'b1);
      both += int'(ph1 === 1'b1 && ph2 === 1'b1);
      rs += int'(read_strobe === 1'b1);
      stray += int'(read_strobe === 1'b1 && ph2 !== 1'b1);
    end
    check("phase one width", p1, 6);
    check("phase two width", p2, 6);
    check("phase overlap", both, 0);
    check("read strobe width", rs, 4);
    check("strobe outside phase two", stray, 0);
  endtask

  // two full turns of the refresh counter, 224 cycles each
  task t_refresh();
    int pulses;
    int bank0;
    int g;
    int t;
    pulses = 0;
    bank0 = 0;
    g = 0;
    t = 0;
    repeat (448) begin
      @(posedge clk);
      pulses += int'(rscan === 1'b1);
      bank0 += int'(refclk[0] === 1'b1);
      g += int'(guard === 1'b1);
      t += int'(tape === 1'b1);
    end
    check("scan step pulses", pulses, 2);
    check("refresh bank zero", bank0, 48);
    check("guard clock high", g, 224);
    check("tape clock high", t, 224);
  endtask

  task t_modifier();
    int n;
    n = 0;
    bus(1'b1, kms_pkg::REG_IRQ_EN, 32'h1);
    bus(1'b1, kms_pkg::REG_CTRL, 32'h1);
    upper_n <= 1'b0;
    control_n <= 1'b0;
    while (view !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    check("view trigger", view, 1);
    repeat (300) @(posedge clk);
    check("upper on link", lnk.upper_case_modifier_n, 0);
    check("control on link", lnk.control_modifier_n, 0);
    check("no key from modifiers", lnk.key_found_n, 1);
    bus(1'b0, kms_pkg::REG_STATUS, 32'h0);
    // status keeps the levels taken with the last key
    check("modifier status", rd[9:8], 2'b11);
    bus(1'b0, kms_pkg::REG_IRQ_STAT, 32'h0);
    check("view event only", rd, 2);
    check("masked irq", irq, 0);
    bus(1'b1, kms_pkg::REG_IRQ_EN, 32'h3);
    check("unmasked irq", irq, 1);
    bus(1'b1, kms_pkg::REG_IRQ_CLR, 32'h2);
    check("cleared irq", irq, 0);
    upper_n <= 1'b1;
    control_n <= 1'b1;
  endtask

  task t_key_held();
    keys[kms_pkg::CODE_A - 1] <= 1'b1;
    bus(1'b0, kms_pkg::REG_CTRL, 32'h0);
    check("ctrl readback", rd, 1);
    wait_key();
    check("letter code", lnk.key_code_lines, kms_pkg::CODE_A);
    check("key line low", lnk.key_found_n, 0);
    @(posedge clk);
    check("host holds", lnk.scan_hold, 1);
    bus(1'b0, kms_pkg::REG_IRQ_STAT, 32'h0);
    check("key event", rd, 1);
    check("key irq", irq, 1);
    bus(1'b0, kms_pkg::REG_STATUS, 32'h0);
    check("letter position", rd[6:0], kms_pkg::CODE_A - 1);
    check("key held flag", rd[7], 1);
    check("no modifiers with key", rd[9:8], 2'b11);
    repeat (1000) @(posedge clk);
    check("code past window", lnk.key_code_lines, kms_pkg::CODE_A);
    bus(1'b1, kms_pkg::REG_IRQ_CLR, 32'h1);
    check("irq cleared", irq, 0);
  endtask

  task t_next_lap();
    int n;
    int pulses;
    n = 0;
    pulses = 0;
    keys <= '0;
    control_n <= 1'b0;
    bus(1'b1, kms_pkg::REG_CTRL, 32'h3);
    check("hold released", lnk.scan_hold, 0);
    while (lnk.key_found_n !== 1'b1 && n < 30000) begin
      @(posedge clk);
      pulses += int'(lnk.key_irq === 1'b1);
      n++;
    end
    check("lap end", lnk.key_found_n, 1);
    check("empty lap quiet", pulses, 0);
    keys[kms_pkg::CODE_PAD0 - 1] <= 1'b1;
    wait_key();
    check("pad code", lnk.key_code_lines, kms_pkg::CODE_PAD0);
    @(posedge clk);
    keys <= '0;
    bus(1'b0, kms_pkg::REG_STATUS, 32'h0);
    check("pad position", rd[6:0], kms_pkg::CODE_PAD0 - 1);
    check("control with pad", rd[9:8], 2'b01);
    // let the code stand a while before the scan goes on
    repeat (8) @(posedge clk);
    control_n <= 1'b1;
    bus(1'b1, kms_pkg::REG_CTRL, 32'h3);
    check("released again", lnk.scan_hold, 0);
  endtask

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    keys = '0;
    upper_n = 1'b1;
    control_n = 1'b1;
    av_addr = 5'h00;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timing();
    t_refresh();
    t_modifier();
    t_key_held();
    t_next_lap();
    give_verdict();
  end
endmodule
`default_nettype wire
